// file: rtl/bss_pkg.sv
// Purpose: shared constants and types for the buck soft-start sequencer
// Assumes: 200 MHz system clock, switching clock seen as a synchronous level
// Notes:   cycle counts are derived from the printed figures
package bss_pkg;

  // system clock
  localparam int CLK_HZ        = 200_000_000;

  // start-up sequence lengths, in switching-clock cycles
  localparam int SS_CYCLES     = 512;
  localparam int SS_QUARTER    = SS_CYCLES / 4;
  localparam int PRE_CYCLES    = 64;
  localparam int RETRY_CYCLES  = 512;

  // pre-charge pulse train, 50% duty
  localparam int PRE_HZ        = 1_500_000;
  localparam int PRE_HALF_CYC  = CLK_HZ / (2 * PRE_HZ);

  // switching-frequency window
  localparam int FSW_MIN_HZ    = 100_000;
  localparam int FSYNC_MIN_HZ  = 350_000;
  localparam int FSW_MAX_HZ    = 700_000;
  localparam int PER_MIN_CYC   = (CLK_HZ + FSW_MAX_HZ - 1) / FSW_MAX_HZ;
  localparam int PER_MAX_RES   = CLK_HZ / FSW_MIN_HZ;
  localparam int PER_MAX_SYNC  = CLK_HZ / FSYNC_MIN_HZ;

  // gate non-overlap interval
  localparam int DEAD_NS       = 20;
  localparam int DEAD_CYC      = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // typed forms of the counts
  localparam logic [9:0]  SS_LAST      = 10'(SS_CYCLES - 1);
  localparam logic [9:0]  SS_QTR       = 10'(SS_QUARTER);
  localparam logic [9:0]  PRE_LAST     = 10'(PRE_CYCLES - 1);
  localparam logic [9:0]  RETRY_LAST   = 10'(RETRY_CYCLES - 1);
  localparam logic [9:0]  TARGET_FULL  = 10'(SS_CYCLES);
  localparam logic [6:0]  PRE_DIV_LAST = 7'(PRE_HALF_CYC - 1);
  localparam logic [11:0] PER_MIN      = 12'(PER_MIN_CYC);
  localparam logic [11:0] PER_MAX_R    = 12'(PER_MAX_RES);
  localparam logic [11:0] PER_MAX_S    = 12'(PER_MAX_SYNC);
  localparam logic [11:0] PER_SAT      = 12'hFFF;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_PRE   = 6'h02,
    ST_SS    = 6'h04,
    ST_RUN   = 6'h08,
    ST_RETRY = 6'h10,
    ST_SPARE = 6'h20
  } bss_state_type;

endpackage

// file: rtl/bss_gate_if.sv
// Purpose: gate request bundle from sequencer to gate driver
// Assumes: requests are never both high
// Notes:   none
`timescale 1ns/10ps
interface bss_gate_if;
  logic want_hs;
  logic want_ls;
  modport src (output want_hs, output want_ls);
  modport drv (input  want_hs, input  want_ls);
endinterface

// file: rtl/bss_gate_drv.sv
// Purpose: gate driver with non-overlap insertion
// Assumes: one clock, synchronous reset
// Notes:   a released gate holds both low for DEAD + 1 cycles
`timescale 1ns/10ps
module bss_gate_drv
  import bss_pkg::*;
#(
  parameter int DEAD = DEAD_CYC
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // requests
  bss_gate_if.drv   g,
  // gate pins
  output logic      o_top,
  output logic      o_bottom
);

  logic       hs_r;
  logic       hs_nxt;
  logic       ls_r;
  logic       ls_nxt;
  logic [3:0] dead_r;
  logic [3:0] dead_nxt;

  always_comb begin
    hs_nxt   = hs_r;
    ls_nxt   = ls_r;
    dead_nxt = dead_r;
    if ((hs_r && !g.want_hs) || (ls_r && !g.want_ls)) begin
      hs_nxt   = hs_r && g.want_hs;
      ls_nxt   = ls_r && g.want_ls;
      dead_nxt = 4'(DEAD);
    end else if (dead_r != 4'h0) begin
      dead_nxt = dead_r - 4'h1;
    end else if (!hs_r && !ls_r) begin
      hs_nxt = g.want_hs && !g.want_ls;
      ls_nxt = g.want_ls && !g.want_hs;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hs_r   <= 1'b0;
      ls_r   <= 1'b0;
      dead_r <= 4'h0;
    end else begin
      hs_r   <= hs_nxt;
      ls_r   <= ls_nxt;
      dead_r <= dead_nxt;
    end
  end

  assign o_top    = hs_r;
  assign o_bottom = ls_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  gate_no_overlap_a: assert property (!(hs_r && ls_r))
    else $error("both gates on");
  top_dead_a: assert property ($rose(hs_r) |-> !$past(ls_r, DEAD + 1))
    else $error("top gate rose inside dead time");
  bottom_dead_a: assert property ($rose(ls_r) |-> !$past(hs_r, DEAD + 1))
    else $error("bottom gate rose inside dead time");

endmodule

// file: rtl/bss_buck_softstart_sequencer.sv
// Purpose: start-up and protection sequencer of a synchronous buck controller
// Assumes: all inputs synchronous to i_clk, switching clock as a level on i_rate_clk
// Notes:   gate pins are driven through a non-overlap stage
`timescale 1ns/10ps
module bss_buck_softstart_sequencer
  import bss_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // control and analog indications
  input  wire logic       i_enable,
  input  wire logic       i_rate_clk,
  input  wire logic       i_resistor_set_rate_mode,
  input  wire logic       i_supply_low_fault,
  input  wire logic       i_output_overvoltage,
  input  wire logic       i_output_precharged,
  input  wire logic       i_pwm_demand,
  // gate pins
  output logic            o_top_gate_drive,
  output logic            o_bottom_gate_drive,
  // status
  output logic [9:0]      o_ramp_target,
  output logic            o_ramp_quarter_done,
  output logic            o_soft_start_busy,
  output logic            o_retry_wait,
  output logic            o_running,
  output logic            o_rate_out_of_range
);

  bss_gate_if gate ();

  bss_state_type st_r;
  bss_state_type st_nxt;
  logic [9:0]    cnt_r;
  logic [9:0]    cnt_nxt;
  logic [9:0]    tgt_r;
  logic [9:0]    tgt_nxt;
  logic [6:0]    pdiv_r;
  logic [6:0]    pdiv_nxt;
  logic          pph_r;
  logic          pph_nxt;
  logic          qtr_r;
  logic          qtr_nxt;
  logic          en_prev_r;
  logic          rclk_prev_r;
  logic [11:0]   per_r;
  logic [11:0]   per_nxt;
  logic          rbad_r;
  logic          rbad_nxt;
  logic          tick;
  logic          uv_seen;
  logic [11:0]   per_max;

  // rising edge of the switching clock is the sequencer's time base
  assign tick    = i_rate_clk && !rclk_prev_r;
  assign uv_seen = i_supply_low_fault && (cnt_r >= SS_QTR);

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    tgt_nxt  = tgt_r;
    pdiv_nxt = pdiv_r;
    pph_nxt  = pph_r;
    qtr_nxt  = 1'b0;
    case (st_r)
      ST_OFF: begin
        tgt_nxt = 10'h000;
        if (i_enable && !en_prev_r) begin
          st_nxt   = ST_PRE;
          cnt_nxt  = 10'h000;
          pdiv_nxt = 7'h00;
          pph_nxt  = 1'b1;
        end
      end
      ST_PRE: begin
        if (pdiv_r == PRE_DIV_LAST) begin
          pdiv_nxt = 7'h00;
          pph_nxt  = !pph_r;
        end else begin
          pdiv_nxt = pdiv_r + 7'h01;
        end
        if (tick) begin
          cnt_nxt = cnt_r + 10'h001;
          if (cnt_r == PRE_LAST) begin
            st_nxt  = ST_SS;
            cnt_nxt = 10'h000;
          end
        end
      end
      ST_SS: begin
        if (uv_seen) begin
          st_nxt  = ST_RETRY;
          cnt_nxt = 10'h000;
          tgt_nxt = 10'h000;
        end else if (tick) begin
          cnt_nxt = cnt_r + 10'h001;
          tgt_nxt = cnt_r + 10'h001;
          qtr_nxt = (cnt_r == SS_QTR - 10'h001);
          if (cnt_r == SS_LAST) begin
            st_nxt  = ST_RUN;
            cnt_nxt = 10'h000;
          end
        end
      end
      ST_RUN: begin
        tgt_nxt = TARGET_FULL;
        if (i_supply_low_fault) begin
          st_nxt  = ST_RETRY;
          cnt_nxt = 10'h000;
          tgt_nxt = 10'h000;
        end
      end
      ST_RETRY: begin
        if (tick) begin
          cnt_nxt = cnt_r + 10'h001;
          if (cnt_r == RETRY_LAST) begin
            st_nxt  = ST_SS;
            cnt_nxt = 10'h000;
          end
        end
      end
      default: begin
        st_nxt  = ST_OFF;
        cnt_nxt = 10'h000;
      end
    endcase
    if (!i_enable) begin
      st_nxt  = ST_OFF;
      cnt_nxt = 10'h000;
      tgt_nxt = 10'h000;
      qtr_nxt = 1'b0;
    end
  end

  // gate requests
  always_comb begin
    gate.want_hs = 1'b0;
    gate.want_ls = 1'b0;
    if ((st_r == ST_SS) || (st_r == ST_RUN)) begin
      if (i_output_overvoltage) begin
        gate.want_ls = 1'b1;
      end else if (!(i_output_precharged && (st_r == ST_SS))) begin
        gate.want_hs = i_pwm_demand;
        gate.want_ls = !i_pwm_demand;
      end
    end else if ((st_r == ST_PRE) && !i_output_precharged) begin
      gate.want_ls = pph_r;
    end
  end

  // switching-period check
  always_comb begin
    per_max  = i_resistor_set_rate_mode ? PER_MAX_R : PER_MAX_S;
    per_nxt  = (per_r == PER_SAT) ? per_r : per_r + 12'h001;
    rbad_nxt = rbad_r;
    if (tick) begin
      per_nxt  = 12'h001;
      rbad_nxt = (per_r < PER_MIN) || (per_r > per_max);
    end else if (per_r > per_max) begin
      rbad_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r        <= ST_OFF;
      cnt_r       <= 10'h000;
      tgt_r       <= 10'h000;
      pdiv_r      <= 7'h00;
      pph_r       <= 1'b0;
      qtr_r       <= 1'b0;
      en_prev_r   <= 1'b1;
      rclk_prev_r <= 1'b1;  // no false tick if the rate pin is high at release
      per_r       <= 12'h000;
      rbad_r      <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      tgt_r       <= tgt_nxt;
      pdiv_r      <= pdiv_nxt;
      pph_r       <= pph_nxt;
      qtr_r       <= qtr_nxt;
      en_prev_r   <= i_enable;
      rclk_prev_r <= i_rate_clk;
      per_r       <= per_nxt;
      rbad_r      <= rbad_nxt;
    end
  end

  bss_gate_drv #(
    .DEAD (DEAD_CYC)
  ) u_drv (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .g        (gate.drv),
    .o_top    (o_top_gate_drive),
    .o_bottom (o_bottom_gate_drive)
  );

  assign o_ramp_target       = tgt_r;
  assign o_ramp_quarter_done = qtr_r;
  assign o_soft_start_busy   = (st_r == ST_SS);
  assign o_retry_wait        = (st_r == ST_RETRY);
  assign o_running           = (st_r == ST_RUN);
  assign o_rate_out_of_range = rbad_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  off_quiet_a: assert property (!i_enable |=> (st_r == ST_OFF) ##1 !gate.want_hs)
    else $error("not off while enable low");
  start_pre_a: assert property ((st_r == ST_OFF) && i_enable && !en_prev_r
      |=> st_r == ST_PRE)
    else $error("enable rise did not start pre-charge");
  pre_end_a: assert property ((st_r == ST_PRE) && tick && (cnt_r == PRE_LAST) && i_enable
      |=> (st_r == ST_SS) && (cnt_r == 10'h000))
    else $error("pre-charge length wrong");
  pre_half_a: assert property ((st_r == ST_PRE) && $changed(pph_r) && i_enable
      |-> pdiv_r == 7'h00)
    else $error("pre-charge toggle off divider");
  ramp_end_a: assert property ((st_r == ST_SS) && tick && (cnt_r == SS_LAST)
      && !i_supply_low_fault && i_enable |=> (st_r == ST_RUN) && (tgt_r == TARGET_FULL))
    else $error("ramp did not end at 512");
  uv_masked_a: assert property ((st_r == ST_SS) && (cnt_r < SS_QTR) && i_enable
      |=> st_r != ST_RETRY)
    else $error("undervoltage acted before quarter");
  uv_abort_a: assert property ((st_r == ST_SS) && (cnt_r >= SS_QTR) && i_supply_low_fault
      && i_enable |=> st_r == ST_RETRY)
    else $error("undervoltage not aborting ramp");
  retry_back_a: assert property ((st_r == ST_RETRY) && tick && (cnt_r == RETRY_LAST)
      && i_enable |=> (st_r == ST_SS) && (tgt_r == 10'h000))
    else $error("retry wait wrong");
  ov_discharge_a: assert property (((st_r == ST_SS) || (st_r == ST_RUN)) && i_output_overvoltage
      |-> gate.want_ls && !gate.want_hs)
    else $error("overvoltage not discharging");
  precharged_hiz_a: assert property (((st_r == ST_PRE) || (st_r == ST_SS))
      && i_output_precharged && !i_output_overvoltage |-> !gate.want_hs && !gate.want_ls)
    else $error("pre-charged output driven");
  run_compl_a: assert property ((st_r == ST_RUN) && !i_output_overvoltage
      |-> (gate.want_hs == i_pwm_demand) && (gate.want_ls != i_pwm_demand))
    else $error("run not complementary");
  rate_fast_a: assert property (tick && (per_r < PER_MIN) |=> rbad_r)
    else $error("fast rate not flagged");

  reach_run_c:   cover property ((st_r == ST_SS) ##1 (st_r == ST_RUN));
  uv_retry_c:    cover property ((st_r == ST_RETRY) ##1 (st_r == ST_SS));
  ov_event_c:    cover property ((st_r == ST_RUN) && i_output_overvoltage);
  precharged_c:  cover property ((st_r == ST_SS) && i_output_precharged);

endmodule

// file: test/bss_switch_model.sv
// Purpose: behavioural model of the external top and bottom power switches
// Assumes: gate pins active high, sampled on the system clock
// Notes:   node flips each cycle while both switches are off (high impedance)
`timescale 1ns/10ps
module bss_switch_model (
  // clock
  input  wire logic i_clk,
  // gates
  input  wire logic i_top,
  input  wire logic i_bottom,
  // switch node and fault count
  output logic      o_node,
  output int        o_overlaps
);
  initial begin
    o_overlaps = 0;
    o_node     = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_top && i_bottom)
      o_overlaps <= o_overlaps + 1;
    if (i_top)
      o_node <= 1'b1;
    else if (i_bottom)
      o_node <= 1'b0;
    else
      o_node <= ~o_node;
  end
endmodule

// file: test/tb_top.sv
// Purpose: self-checking bench of the soft-start sequencer
// Assumes: switching clock made here, one tick every 8 system clocks, slowed to 400 and 800 in t_rate
// Notes:   fast switching clock keeps runs short; rate flag expected high
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t value mismatch", $time); end end
`define WAIT(c, n) for (k = 0; k < (n) && !(c); k++) begin @(posedge i_clk); #1; end
module tb_top;
  import bss_pkg::*;
  logic       i_clk = 1'b0, i_srst = 1'b1, en = 1'b0, rck = 1'b0;
  logic       uv = 1'b0, ov = 1'b0, pc = 1'b0, pwm = 1'b0;
  logic       top, bot, qd, busy, rw, run, bad, seen = 1'b0, rw_seen = 1'b0;
  logic       node, rmode = 1'b1;
  logic [9:0] tgt;
  int         mismatches = 0, total_checks = 0, ticks = 0, rdiv = 0, k, n, ovl;
  int         rhalf = 4;
  time        t0;

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    rdiv <= (rdiv >= rhalf - 1) ? 0 : rdiv + 1;
    if (rdiv >= rhalf - 1) begin
      rck <= ~rck;
      if (!rck)
        ticks <= ticks + 1;
    end
    if (top | bot)
      seen <= 1'b1;
    if (rw)
      rw_seen <= 1'b1;
  end

  bss_buck_softstart_sequencer uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_enable(en), .i_rate_clk(rck),
    .i_resistor_set_rate_mode(rmode), .i_supply_low_fault(uv),
    .i_output_overvoltage(ov), .i_output_precharged(pc), .i_pwm_demand(pwm),
    .o_top_gate_drive(top), .o_bottom_gate_drive(bot), .o_ramp_target(tgt),
    .o_ramp_quarter_done(qd), .o_soft_start_busy(busy), .o_retry_wait(rw),
    .o_running(run), .o_rate_out_of_range(bad));
  bss_switch_model u_sw (.i_clk(i_clk), .i_top(top), .i_bottom(bot),
    .o_node(node), .o_overlaps(ovl));

  task wrap_up;
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task start;
    @(posedge i_clk) en <= 1'b0;
    repeat (2) @(posedge i_clk);
    en <= 1'b1;
    n = ticks;
    @(posedge i_clk);
    #1;
  endtask

  task t_run;
    start;
    `WAIT(bot, 20)
    `WAIT(!bot, 200)
    `WAIT(bot, 200)
    t0 = $time;
    `CHK(top, 1'b0)
    `WAIT(!bot, 200)
    `WAIT(bot, 200)
    `CHK($time - t0, 660)
    `WAIT(tgt == 10'h001, 8000)
    `CHK((ticks - n) inside {[64:66]}, 1'b1)
    n = ticks;
    `WAIT(qd, 2000)
    `CHK(tgt, 10'h080)
    `WAIT(run, 8000)
    `CHK(tgt, 10'h200)
    `CHK((ticks - n) inside {[510:512]}, 1'b1)
    @(posedge i_clk) pwm <= 1'b1;
    repeat (10) @(posedge i_clk);
    #1 `CHK({top, bot, node}, 3'h5)
    @(posedge i_clk) pwm <= 1'b0;
    repeat (10) @(posedge i_clk);
    #1 `CHK({top, bot, node}, 3'h2)
    @(posedge i_clk) pwm <= 1'b1;
    ov <= 1'b1;
    repeat (10) @(posedge i_clk);
    #1 `CHK({top, bot, node}, 3'h2)
    `CHK(bad, 1'b1)
    @(posedge i_clk) ov <= 1'b0;
    en <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 `CHK({busy, run, top, bot}, 4'h0)
  endtask

  task t_uv_early;
    start;
    `WAIT(tgt == 10'h010, 8000)
    rw_seen = 1'b0;
    @(posedge i_clk) uv <= 1'b1;
    `WAIT(tgt == 10'h07F, 2000)
    @(posedge i_clk) uv <= 1'b0;
    `WAIT(run, 8000)
    `CHK(run, 1'b1)
    `CHK(rw_seen, 1'b0)
  endtask

  task t_uv_late;
    start;
    `WAIT(tgt == 10'h080, 8000)
    @(posedge i_clk) uv <= 1'b1;
    `WAIT(rw, 4)
    `CHK(rw, 1'b1)
    n = ticks;
    #5 `CHK({tgt, top, bot}, 12'h000)
    @(posedge i_clk) uv <= 1'b0;
    `WAIT(!rw, 6000)
    `CHK((ticks - n) inside {[511:513]}, 1'b1)
    `WAIT(tgt == 10'h002, 40)
    `CHK(tgt, 10'h002)
  endtask

  task t_precharged;
    @(posedge i_clk) pc <= 1'b1;
    start;
    seen = 1'b0;
    `WAIT(tgt == 10'h020, 8000)
    `CHK(tgt, 10'h020)
    `CHK(seen, 1'b0)
    @(posedge i_clk) pc <= 1'b0;
    `CHK(ovl, 0)
  endtask

  task t_reset;
    @(posedge i_clk) i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (20) @(posedge i_clk);
    #1 `CHK({top, bot, busy, run, rw, tgt}, 15'h0000)
  endtask

  task t_rate;
    rhalf = 200;
    repeat (1600) @(posedge i_clk);
    #1 `CHK(bad, 1'b0)
    @(posedge i_clk) rmode <= 1'b0;
    repeat (800) @(posedge i_clk);
    #1 `CHK(bad, 1'b0)
    rhalf = 400;
    repeat (2400) @(posedge i_clk);
    #1 `CHK(bad, 1'b1)
    @(posedge i_clk) rmode <= 1'b1;
    repeat (1600) @(posedge i_clk);
    #1 `CHK(bad, 1'b0)
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    #1 `CHK({top, bot, busy, run, rw, tgt}, 15'h0000)
    t_run;
    t_uv_early;
    t_uv_late;
    t_precharged;
    t_reset;
    t_rate;
    wrap_up;
  end

  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    wrap_up;
  end
endmodule
